// ==== shared/opc_pkg.sv ====
// Constants and types shared by the operator panel control logic.
package opc_pkg;

   // System clock rate and the derived period.
   localparam int CLK_FREQ_MHZ = 40;
   localparam int CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;

   // Field widths.
   localparam int SW_W = 14;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 8;
   localparam int KEY_W = 8;
   localparam int STAT_W = 12;
   localparam int LAMP_W = 13;
   localparam int CNT_W = 8;

   // Times in their own units, with cycle counts derived from them.
   localparam int PHASE_RATE_KHZ = 500;
   localparam int PHASE_PERIOD_NS = 1000000 / PHASE_RATE_KHZ;
   localparam int LAMP_HOLD_NS = 2 * PHASE_PERIOD_NS;
   localparam int LAMP_HOLD_CYC = (LAMP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_PULSE_NS = 5000;
   localparam int START_PULSE_CYC = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEBOUNCE_US = 5000;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Bit positions of the debounced panel controls.
   localparam int KEY_ADDR_LOAD = 0;
   localparam int KEY_START = 1;
   localparam int KEY_RESUME = 2;
   localparam int KEY_EXAMINE = 3;
   localparam int KEY_DEPOSIT = 4;
   localparam int KEY_STEP = 5;
   localparam int KEY_SHOW_DATA = 6;
   localparam int KEY_SHOW_ADDR = 7;

   // Bit positions of the synchronised processor status lines.
   localparam int ST_STOP = 0;
   localparam int ST_WAIT = 1;
   localparam int ST_FETCH = 2;
   localparam int ST_READ = 3;
   localparam int ST_WRITE = 4;
   localparam int ST_IO = 5;
   localparam int ST_READY = 6;
   localparam int ST_INTERRUPT_LAMP = 7;
   localparam int ST_PHI1 = 8;
   localparam int ST_PHI2 = 9;
   localparam int ST_SYNC = 10;
   localparam int ST_TS1 = 11;

   // Bit positions of the status lamp vector.
   localparam int LP_RUN = 0;
   localparam int LP_HALT = 1;
   localparam int LP_WAIT = 2;
   localparam int LP_FETCH = 3;
   localparam int LP_READ = 4;
   localparam int LP_WRITE = 5;
   localparam int LP_IO = 6;
   localparam int LP_READY = 7;
   localparam int LP_INTERRUPT_LAMP = 8;
   localparam int LP_PHI1 = 9;
   localparam int LP_PHI2 = 10;
   localparam int LP_SYNC = 11;
   localparam int LP_STEP = 12;

   // Panel control states.
   typedef enum logic [4:0] {
      OPC_RUN  = 5'h01,
      OPC_HOLD = 5'h02,
      OPC_STEP = 5'h04,
      OPC_MRD  = 5'h08,
      OPC_MWR  = 5'h10
   } opc_state_e;

endpackage

// ==== hw/opc_debounce.sv ====
// Synchroniser and debouncer for a group of panel keys and switches.
`timescale 1ns/100ps
`default_nettype none
module opc_debounce #(
   parameter int W = 8,
   parameter int HOLD_CYC = 200000
) (
   // Clock and reset.
   input  wire logic         clk_in,
   input  wire logic         resetn_in,
   // Raw contacts and clean results.
   input  wire logic [W-1:0] raw_in,
   output logic      [W-1:0] level_out,
   output logic      [W-1:0] rise_out
);
   localparam int CW = $clog2(HOLD_CYC + 1);

   typedef struct packed {
      logic [W-1:0]         s1;
      logic [W-1:0]         s2;
      logic [W-1:0]         s3;
      logic [W-1:0]         level;
      logic [W-1:0]         rise;
      logic [W-1:0][CW-1:0] cnt;
   } opc_db_s;

   opc_db_s st_reg;
   opc_db_s st_next;

   // A new level is taken once the last two stages agree for the whole hold time.
   always_comb begin
      st_next = st_reg;
      st_next.s1 = raw_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.rise = '0;
      for (int i = 0; i < W; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i] && st_reg.s3[i] != st_reg.level[i]) begin
            if (st_reg.cnt[i] == CW'(HOLD_CYC - 1)) begin
               st_next.cnt[i] = '0;
               st_next.level[i] = st_reg.s3[i];
               st_next.rise[i] = st_reg.s3[i];
            end else begin
               st_next.cnt[i] = st_reg.cnt[i] + CW'(1);
            end
         end else begin
            st_next.cnt[i] = '0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_out = st_reg.level;
   assign rise_out = st_reg.rise;
endmodule
`default_nettype wire

// ==== hw/opc_panel.sv ====
// Operator panel control: keys, switch register, memory access and status lamps.
// How it works
// - Fourteen switches feed address load, examine and deposit as address or data.
// - Address load while halted copies the switches into the current address.
// - Resume with single step on releases the processor for one machine cycle.
// - Resume with single step off lets the processor run freely.
// - Examine reads the switch address, then each repeat reads the next address.
// - Deposit writes the low switch byte to the current address, loaded or last examined.
// - The single step switch makes execution advance one cycle per resume.
// - Data display shows the byte read by the latest examine.
// - Address display shows the loaded or examined address.
// - Run lamp lit while the processor stopped line is low; halt lamp lit while it is high.
// - Wait lamp follows the processor wait state.
// - Fetch, read, write and I/O lamps follow the current cycle type.
// - Ready and interrupt lamps follow the processor ready and interrupt lines.
// - Timing lamps show activity of both clock phases and of sync.
// - Works with the two-phase processor clock at 500 kHz over short cable.
`timescale 1ns/100ps
`default_nettype none
module opc_panel
   import opc_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = opc_pkg::DEBOUNCE_CYC
) (
   // Clock and reset.
   input  wire logic                         CLK_SYS_IN,
   input  wire logic                         RESETN_IN,
   // Panel keys and switches, high while pressed or on.
   input  wire logic [opc_pkg::SW_W-1:0]     SWITCH_REG_IN,
   input  wire logic                         ADDR_LOAD_KEY_IN,
   input  wire logic                         RUN_START_KEY_IN,
   input  wire logic                         RESUME_KEY_IN,
   input  wire logic                         EXAMINE_KEY_IN,
   input  wire logic                         DEPOSIT_KEY_IN,
   input  wire logic                         SINGLE_STEP_SWITCH_IN,
   input  wire logic                         SHOW_DATA_SELECT_IN,
   input  wire logic                         SHOW_ADDRESS_SELECT_IN,
   // Processor status lines, asynchronous to the system clock.
   input  wire logic                         PROC_STOPPED_IN,
   input  wire logic                         PROC_WAIT_IN,
   input  wire logic                         FETCH_CYCLE_IN,
   input  wire logic                         READ_CYCLE_IN,
   input  wire logic                         WRITE_CYCLE_IN,
   input  wire logic                         IO_CYCLE_IN,
   input  wire logic                         PROC_READY_IN,
   input  wire logic                         PROC_INTERRUPT_IN,
   input  wire logic                         PHASE1_CLK_IN,
   input  wire logic                         PHASE2_CLK_IN,
   input  wire logic                         STATE_SYNC_IN,
   input  wire logic                         PROC_TS1_IN,
   // Processor control.
   output logic                              PROC_START_OUT,
   output logic                              PROC_RUN_ENABLE_OUT,
   // Memory port used while the processor is halted.
   output logic                              MEM_REQ_OUT,
   output logic                              MEM_WE_OUT,
   output logic [opc_pkg::ADDR_W-1:0]        MEM_ADDR_OUT,
   output logic [opc_pkg::DATA_W-1:0]        MEM_WDATA_OUT,
   input  wire logic [opc_pkg::DATA_W-1:0]   MEM_RDATA_IN,
   input  wire logic                         MEM_ACK_IN,
   // Lamps.
   output logic [opc_pkg::SW_W-1:0]          DISPLAY_LAMPS_OUT,
   output logic [opc_pkg::LAMP_W-1:0]        STATUS_LAMPS_OUT
);
   import opc_pkg::*;

   typedef struct packed {
      opc_state_e          state;
      logic                ret_run;
      logic                exam_seen;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
      logic [DATA_W-1:0]   wdata;
      logic                mem_req;
      logic                mem_we;
      logic                run_en;
      logic                start;
      logic [CNT_W-1:0]    start_cnt;
      logic [STAT_W-1:0]   s1;
      logic [STAT_W-1:0]   s2;
      logic [STAT_W-1:0]   s3;
      logic [STAT_W-1:0]   filt;
      logic [STAT_W-1:0]   prev;
      logic [CNT_W-1:0]    phi1_cnt;
      logic [CNT_W-1:0]    phi2_cnt;
      logic [CNT_W-1:0]    sync_cnt;
      logic [SW_W-1:0]     display;
      logic [LAMP_W-1:0]   lamps;
   } opc_panel_s;

   opc_panel_s        st_reg;
   opc_panel_s        st_next;
   logic [KEY_W-1:0]  key_level;
   logic [KEY_W-1:0]  key_rise;
   logic [STAT_W-1:0] stat_raw;

   // Reloads on each rising edge of a timing line, else counts down toward dark.
   function automatic logic [CNT_W-1:0] stretch(input logic [CNT_W-1:0] cnt,
                                                 input logic edge_seen);
      logic [CNT_W-1:0] res;
      res = cnt;
      if (edge_seen) begin
         res = CNT_W'(LAMP_HOLD_CYC);
      end else if (cnt != '0) begin
         res = cnt - CNT_W'(1);
      end
      return res;
   endfunction

   opc_debounce #(
      .W        (KEY_W),
      .HOLD_CYC (DEBOUNCE_CYCLES)
   ) u_keys (
      .clk_in    (CLK_SYS_IN),
      .resetn_in (RESETN_IN),
      .raw_in    ({SHOW_ADDRESS_SELECT_IN, SHOW_DATA_SELECT_IN, SINGLE_STEP_SWITCH_IN,
                   DEPOSIT_KEY_IN, EXAMINE_KEY_IN, RESUME_KEY_IN, RUN_START_KEY_IN,
                   ADDR_LOAD_KEY_IN}),
      .level_out (key_level),
      .rise_out  (key_rise)
   );

   assign stat_raw = {PROC_TS1_IN, STATE_SYNC_IN, PHASE2_CLK_IN, PHASE1_CLK_IN,
                      PROC_INTERRUPT_IN, PROC_READY_IN, IO_CYCLE_IN, WRITE_CYCLE_IN,
                      READ_CYCLE_IN, FETCH_CYCLE_IN, PROC_WAIT_IN, PROC_STOPPED_IN};

   always_comb begin
      logic halted;
      logic ts1_rise;
      logic idle;
      halted = 1'b0;
      ts1_rise = 1'b0;
      idle = 1'b0;
      st_next = st_reg;

      // Status lines pass three stages; a change counts once the last two agree.
      st_next.s1 = stat_raw;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.prev = st_reg.filt;
      for (int i = 0; i < STAT_W; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.filt[i] = st_reg.s3[i];
         end
      end

      ts1_rise = st_reg.filt[ST_TS1] && !st_reg.prev[ST_TS1];
      halted = st_reg.filt[ST_STOP] || (st_reg.state == OPC_HOLD);
      idle = (st_reg.state == OPC_RUN) || (st_reg.state == OPC_HOLD);

      // Start pulse is held long enough for the slow processor clock to see it.
      st_next.start = 1'b0;
      if (st_reg.start_cnt != '0) begin
         st_next.start_cnt = st_reg.start_cnt - CNT_W'(1);
         st_next.start = 1'b1;
      end else if (key_rise[KEY_START]) begin
         st_next.start_cnt = CNT_W'(START_PULSE_CYC - 1);
         st_next.start = 1'b1;
      end

      case (st_reg.state)
         OPC_RUN: begin
            st_next.run_en = 1'b1;
            if (key_level[KEY_STEP] && ts1_rise) begin
               st_next.run_en = 1'b0;
               st_next.state = OPC_HOLD;
            end
         end
         OPC_HOLD: begin
            st_next.run_en = 1'b0;
            if (key_rise[KEY_RESUME] || key_rise[KEY_START]) begin
               st_next.run_en = 1'b1;
               if (key_level[KEY_STEP] && key_rise[KEY_RESUME]) begin
                  st_next.state = OPC_STEP;
               end else begin
                  st_next.state = OPC_RUN;
               end
            end
         end
         OPC_STEP: begin
            if (ts1_rise) begin
               st_next.run_en = 1'b0;
               st_next.state = OPC_HOLD;
            end
         end
         OPC_MRD: begin
            if (MEM_ACK_IN) begin
               st_next.mem_req = 1'b0;
               st_next.data = MEM_RDATA_IN;
               st_next.exam_seen = 1'b1;
               st_next.state = st_reg.ret_run ? OPC_RUN : OPC_HOLD;
            end
         end
         OPC_MWR: begin
            if (MEM_ACK_IN) begin
               st_next.mem_req = 1'b0;
               st_next.mem_we = 1'b0;
               st_next.state = st_reg.ret_run ? OPC_RUN : OPC_HOLD;
            end
         end
         default: begin
            st_next.state = OPC_HOLD;
            st_next.run_en = 1'b0;
            st_next.mem_req = 1'b0;
            st_next.mem_we = 1'b0;
         end
      endcase

      // Panel memory actions, taken only while halted and idle.
      if (idle && halted && !key_rise[KEY_RESUME] && !key_rise[KEY_START]) begin
         st_next.ret_run = (st_reg.state == OPC_RUN);
         if (key_rise[KEY_ADDR_LOAD]) begin
            st_next.addr = SWITCH_REG_IN;
            st_next.exam_seen = 1'b0;
         end else if (key_rise[KEY_EXAMINE]) begin
            st_next.addr = st_reg.exam_seen ? st_reg.addr + ADDR_W'(1)
                                            : SWITCH_REG_IN;
            st_next.mem_req = 1'b1;
            st_next.state = OPC_MRD;
         end else if (key_rise[KEY_DEPOSIT]) begin
            st_next.wdata = SWITCH_REG_IN[DATA_W-1:0];
            st_next.mem_req = 1'b1;
            st_next.mem_we = 1'b1;
            st_next.state = OPC_MWR;
         end
      end

      // Address and data display.
      if (key_level[KEY_SHOW_DATA]) begin
         st_next.display = {{(SW_W - DATA_W){1'b0}}, st_reg.data};
      end else if (key_level[KEY_SHOW_ADDR]) begin
         st_next.display = st_reg.addr;
      end else begin
         st_next.display = '0;
      end

      // Timing lamps stay lit for two phase periods after each rising edge.
      st_next.phi1_cnt = stretch(st_reg.phi1_cnt,
                                 st_reg.filt[ST_PHI1] && !st_reg.prev[ST_PHI1]);
      st_next.phi2_cnt = stretch(st_reg.phi2_cnt,
                                 st_reg.filt[ST_PHI2] && !st_reg.prev[ST_PHI2]);
      st_next.sync_cnt = stretch(st_reg.sync_cnt,
                                 st_reg.filt[ST_SYNC] && !st_reg.prev[ST_SYNC]);

      st_next.lamps[LP_RUN] = !st_reg.filt[ST_STOP];
      st_next.lamps[LP_HALT] = st_reg.filt[ST_STOP];
      st_next.lamps[LP_WAIT] = st_reg.filt[ST_WAIT];
      st_next.lamps[LP_FETCH] = st_reg.filt[ST_FETCH];
      st_next.lamps[LP_READ] = st_reg.filt[ST_READ];
      st_next.lamps[LP_WRITE] = st_reg.filt[ST_WRITE];
      st_next.lamps[LP_IO] = st_reg.filt[ST_IO];
      st_next.lamps[LP_READY] = st_reg.filt[ST_READY];
      st_next.lamps[LP_INTERRUPT_LAMP] = st_reg.filt[ST_INTERRUPT_LAMP];
      st_next.lamps[LP_PHI1] = (st_reg.phi1_cnt != '0);
      st_next.lamps[LP_PHI2] = (st_reg.phi2_cnt != '0);
      st_next.lamps[LP_SYNC] = (st_reg.sync_cnt != '0);
      st_next.lamps[LP_STEP] = key_level[KEY_STEP];
   end

   always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         st_reg <= '0;
         st_reg.state <= OPC_RUN;
         st_reg.run_en <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign PROC_START_OUT = st_reg.start;
   assign PROC_RUN_ENABLE_OUT = st_reg.run_en;
   assign MEM_REQ_OUT = st_reg.mem_req;
   assign MEM_WE_OUT = st_reg.mem_we;
   assign MEM_ADDR_OUT = st_reg.addr;
   assign MEM_WDATA_OUT = st_reg.wdata;
   assign DISPLAY_LAMPS_OUT = st_reg.display;
   assign STATUS_LAMPS_OUT = st_reg.lamps;
endmodule
`default_nettype wire

// ==== dv/opc_panel_chk.sv ====
// Concurrent checks on the operator panel ports.
`timescale 1ns/100ps
`default_nettype none
module opc_panel_chk
   import opc_pkg::*;
(
   // Clock and reset.
   input  wire logic                       CLK_SYS_IN,
   input  wire logic                       RESETN_IN,
   // Watched lines.
   input  wire logic                       PROC_READY_IN,
   input  wire logic                       PROC_INTERRUPT_IN,
   input  wire logic                       PROC_WAIT_IN,
   input  wire logic                       PROC_TS1_IN,
   input  wire logic                       MEM_ACK_IN,
   input  wire logic                       PROC_START_OUT,
   input  wire logic                       PROC_RUN_ENABLE_OUT,
   input  wire logic                       MEM_REQ_OUT,
   input  wire logic                       MEM_WE_OUT,
   input  wire logic [opc_pkg::ADDR_W-1:0] MEM_ADDR_OUT,
   input  wire logic [opc_pkg::LAMP_W-1:0] STATUS_LAMPS_OUT
);
   logic [8:0] start_cnt_reg;
   logic [8:0] start_cnt_next;
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RESETN_IN);
   // Counts how many edges the start pulse has stood high so far.
   always_comb start_cnt_next = PROC_START_OUT ? start_cnt_reg + 9'h001 : 9'h000;
   always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
      if (!RESETN_IN)
         start_cnt_reg <= 9'h000;
      else
         start_cnt_reg <= start_cnt_next;
   end
   a_start_pulse_width: assert property ($fell(PROC_START_OUT) |-> start_cnt_reg == 9'h0C8)
      else $error("start pulse width wrong");
   a_req_held_stable: assert property (MEM_REQ_OUT && !MEM_ACK_IN |=>
      MEM_REQ_OUT && $stable(MEM_ADDR_OUT) && $stable(MEM_WE_OUT))
      else $error("memory request not held");
   a_req_ends_ack: assert property (MEM_REQ_OUT && MEM_ACK_IN |=> !MEM_REQ_OUT)
      else $error("memory request outlived ack");
   a_write_in_req: assert property (MEM_WE_OUT |-> MEM_REQ_OUT)
      else $error("write strobe outside request");
   a_req_when_halted: assert property ($rose(MEM_REQ_OUT) |->
      !PROC_RUN_ENABLE_OUT || STATUS_LAMPS_OUT[LP_HALT])
      else $error("memory access while running");
   a_addr_kept_run: assert property (PROC_RUN_ENABLE_OUT && STATUS_LAMPS_OUT[LP_RUN]
      |=> $stable(MEM_ADDR_OUT))
      else $error("address moved while running");
   a_ready_lamp_on: assert property ($rose(PROC_READY_IN) |-> ##[3:8] STATUS_LAMPS_OUT[LP_READY])
      else $error("ready lamp not lit");
   a_interrupt_lamp_lamp_off: assert property ($fell(PROC_INTERRUPT_IN) |-> ##[3:8] !STATUS_LAMPS_OUT[LP_INTERRUPT_LAMP])
      else $error("interrupt lamp not cleared");
   a_wait_lamp_on: assert property (PROC_WAIT_IN [*8] |-> STATUS_LAMPS_OUT[LP_WAIT])
      else $error("wait lamp not lit");
   a_step_one_cycle: assert property (PROC_RUN_ENABLE_OUT && STATUS_LAMPS_OUT[LP_STEP]
      && $rose(PROC_TS1_IN) |-> ##[3:8] !PROC_RUN_ENABLE_OUT)
      else $error("single step did not stop");
   a_free_run_kept: assert property (PROC_RUN_ENABLE_OUT && !STATUS_LAMPS_OUT[LP_STEP]
      && $rose(PROC_TS1_IN) |=> PROC_RUN_ENABLE_OUT [*3])
      else $error("free run interrupted");
   c_start: cover property ($fell(PROC_START_OUT));
   c_write: cover property (MEM_WE_OUT && MEM_ACK_IN);
   c_step: cover property ($fell(PROC_RUN_ENABLE_OUT));
endmodule
`default_nettype wire

// ==== dv/opc_proc_model.sv ====
// Behavioural processor and memory on the far side of the panel.
`timescale 1ns/100ps
`default_nettype none
module opc_proc_model
   import opc_pkg::*;
#(
   parameter int CYC_LEN = 12,
   parameter int MEM_LAT = 2
) (
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   // Bench commands.
   input  wire logic        halt_cmd_in,
   input  wire logic        slow_in,
   input  wire logic [6:0]  lines_in,
   // Panel side.
   input  wire logic        start_in,
   input  wire logic        run_en_in,
   input  wire logic        mem_req_in,
   input  wire logic        mem_we_in,
   input  wire logic [13:0] mem_addr_in,
   input  wire logic [7:0]  mem_wdata_in,
   output logic             stopped_out,
   output logic             ts1_out,
   output logic             phase1_out,
   output logic             phase2_out,
   output logic             sync_out,
   output logic [6:0]       lines_out,
   output logic             mem_ack_out,
   output logic [7:0]       mem_rdata_out
);
   logic [7:0] mem [0:16383];
   logic [7:0] last;
   logic [3:0] cyc;
   logic [3:0] ph;
   int         lat;
   initial for (int i = 0; i < 16384; i++) mem[i] = 8'(i) ^ 8'h5A;
   assign lines_out = lines_in;
   assign ts1_out = !stopped_out && (cyc < 4'h2);
   // Phase clocks run free, sped up from the real rate to keep runs short.
   assign phase1_out = (ph[3:2] == 2'h0);
   assign phase2_out = (ph[3:2] == 2'h2);
   // Sync spans half a machine cycle, so the three-stage input filter can follow it.
   assign sync_out = (cyc < 4'h6);
   // Outside an acknowledge the read bus shows the inverse of the last byte.
   assign mem_rdata_out = mem_ack_out ? last : ~last;
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         stopped_out <= 1'b0;
         cyc <= 4'h2;
         ph <= 4'h0;
         lat <= 0;
         last <= 8'h00;
         mem_ack_out <= 1'b0;
      end else begin
         ph <= ph + 4'h1;
         // A halted processor stays stopped until the start line is raised.
         if (halt_cmd_in)
            stopped_out <= 1'b1;
         else if (start_in)
            stopped_out <= 1'b0;
         if (!stopped_out && run_en_in)
            cyc <= (cyc == 4'(CYC_LEN - 1)) ? 4'h0 : cyc + 4'h1;
         mem_ack_out <= 1'b0;
         if (mem_req_in && !mem_ack_out) begin
            if (lat >= (slow_in ? MEM_LAT : 0)) begin
               mem_ack_out <= 1'b1;
               lat <= 0;
               if (mem_we_in)
                  mem[mem_addr_in] <= mem_wdata_in;
               else
                  last <= mem[mem_addr_in];
            end else begin
               lat <= lat + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== dv/opc_panel_bench.sv ====
// Self-checking bench for the operator panel control.
`timescale 1ns/100ps
`default_nettype none
module opc_panel_bench;
   import opc_pkg::*;
   localparam int DEB = 4;
   logic clk, rstn, halt_cmd, slow, stop_l, ts1, ph1, ph2, syn, ack, start, run_en, req, we, ts1_q;
   logic [13:0] sw, addr, disp;
   logic [7:0]  keys, wdata, rdata;
   logic [6:0]  lines, lines_o;
   logic [12:0] lamps;
   int          err_count, n_compared, w, m, ts1_rises;
   // Each row is a status line pattern and also the lamp bits 8:2 it must light.
   logic [6:0]  rows [9] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00};
   opc_panel #(.DEBOUNCE_CYCLES(DEB)) u_dut (.CLK_SYS_IN(clk), .RESETN_IN(rstn),
      .SWITCH_REG_IN(sw), .ADDR_LOAD_KEY_IN(keys[KEY_ADDR_LOAD]),
      .RUN_START_KEY_IN(keys[KEY_START]), .RESUME_KEY_IN(keys[KEY_RESUME]),
      .EXAMINE_KEY_IN(keys[KEY_EXAMINE]), .DEPOSIT_KEY_IN(keys[KEY_DEPOSIT]),
      .SINGLE_STEP_SWITCH_IN(keys[KEY_STEP]), .SHOW_DATA_SELECT_IN(keys[KEY_SHOW_DATA]),
      .SHOW_ADDRESS_SELECT_IN(keys[KEY_SHOW_ADDR]), .PROC_STOPPED_IN(stop_l),
      .PROC_WAIT_IN(lines_o[0]), .FETCH_CYCLE_IN(lines_o[1]), .READ_CYCLE_IN(lines_o[2]),
      .WRITE_CYCLE_IN(lines_o[3]), .IO_CYCLE_IN(lines_o[4]), .PROC_READY_IN(lines_o[5]),
      .PROC_INTERRUPT_IN(lines_o[6]), .PHASE1_CLK_IN(ph1), .PHASE2_CLK_IN(ph2),
      .STATE_SYNC_IN(syn), .PROC_TS1_IN(ts1), .PROC_START_OUT(start),
      .PROC_RUN_ENABLE_OUT(run_en), .MEM_REQ_OUT(req), .MEM_WE_OUT(we), .MEM_ADDR_OUT(addr),
      .MEM_WDATA_OUT(wdata), .MEM_RDATA_IN(rdata), .MEM_ACK_IN(ack),
      .DISPLAY_LAMPS_OUT(disp), .STATUS_LAMPS_OUT(lamps));
   opc_proc_model u_proc (.clk_in(clk), .resetn_in(rstn), .halt_cmd_in(halt_cmd),
      .slow_in(slow), .lines_in(lines), .start_in(start), .run_en_in(run_en),
      .mem_req_in(req), .mem_we_in(we), .mem_addr_in(addr), .mem_wdata_in(wdata),
      .stopped_out(stop_l), .ts1_out(ts1), .phase1_out(ph1), .phase2_out(ph2),
      .sync_out(syn), .lines_out(lines_o), .mem_ack_out(ack), .mem_rdata_out(rdata));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      ts1_q <= ts1;
      if (ts1 && !ts1_q)
         ts1_rises++;
   end
   task automatic stop_test();
      $display("Counts: %0d compared, %0d mismatches", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task automatic press(input int idx);
      keys[idx] = 1'b1;
      cyc(DEB + 8);
      keys[idx] = 1'b0;
      cyc(DEB + 8);
   endtask
   task automatic wait_run(input logic v);
      for (int i = 0; i < 100 && run_en !== v; i++)
         cyc(1);
      check("run enable wait", run_en, v);
      if (run_en !== v)
         stop_test();
   endtask
   initial begin
      #2000000;
      err_count++;
      stop_test();
   end
   initial begin
      {sw, keys, halt_cmd, slow, lines, rstn, ts1_rises, err_count, n_compared} = '0;
      cyc(8);
      check("reset start", start, 1'b0);
      check("reset run enable", run_en, 1'b1);
      rstn = 1'b1;
      cyc(20);
      foreach (rows[i]) begin
         lines = rows[i];
         cyc(10);
         check("status lamps", lamps[8:2], rows[i]);
         check("timing lamps", lamps[11:9], 3'h7);
         check("run lamp", lamps[LP_RUN], 1'b1);
      end
      $display("Lamp table done");
      halt_cmd = 1'b1;
      cyc(1);
      halt_cmd = 1'b0;
      cyc(10);
      check("run lamp", lamps[LP_RUN], 1'b0);
      check("halt lamp", lamps[LP_HALT], 1'b1);
      keys[KEY_SHOW_ADDR] = 1'b1;
      sw = 14'h12A5;
      press(KEY_ADDR_LOAD);
      check("loaded address", addr, 14'h12A5);
      check("address lamps", disp, 14'h12A5);
      keys[KEY_SHOW_ADDR] = 1'b0;
      keys[KEY_SHOW_DATA] = 1'b1;
      for (int k = 0; k < 2; k++) begin
         slow = k[0];
         press(KEY_EXAMINE);
         check("examine address", addr, 14'h12A5 + 14'(k));
         check("data lamps", disp, {6'h00, 8'(8'hA5 + k) ^ 8'h5A});
      end
      sw = 14'h3F81;
      press(KEY_DEPOSIT);
      check("deposit data", u_proc.mem[14'h12A6], 8'h81);
      check("deposit address", addr, 14'h12A6);
      $display("Memory access done");
      keys[KEY_START] = 1'b1;
      w = 0;
      for (int i = 0; i < 400; i++) begin
         if (i == 12)
            keys[KEY_START] = 1'b0;
         if (start === 1'b1)
            w++;
         cyc(1);
      end
      check("start width", 16'(w), 16'(START_PULSE_CYC));
      check("run lamp after start", lamps[LP_RUN], 1'b1);
      sw = 14'h0111;
      press(KEY_ADDR_LOAD);
      press(KEY_DEPOSIT);
      check("address while running", addr, 14'h12A6);
      check("memory while running", u_proc.mem[14'h12A6], 8'h81);
      $display("Start done");
      keys[KEY_STEP] = 1'b1;
      wait_run(1'b0);
      check("step lamp", lamps[LP_STEP], 1'b1);
      for (int k = 0; k < 2; k++) begin
         m = ts1_rises;
         press(KEY_RESUME);
         cyc(30);
         check("step cycles", 16'(ts1_rises - m), 16'h0001);
         check("step stopped", run_en, 1'b0);
      end
      keys[KEY_STEP] = 1'b0;
      cyc(20);
      m = ts1_rises;
      press(KEY_RESUME);
      cyc(40);
      check("free run", run_en, 1'b1);
      check("free cycles", 16'(ts1_rises - m > 2), 16'h0001);
      $display("Run control done");
      rstn = 1'b0;
      cyc(2);
      check("second reset request", req, 1'b0);
      check("second reset run enable", run_en, 1'b1);
      rstn = 1'b1;
      cyc(4);
      $display("Reset done");
      stop_test();
   end
endmodule
bind opc_panel opc_panel_chk u_chk (.CLK_SYS_IN, .RESETN_IN, .PROC_READY_IN,
   .PROC_INTERRUPT_IN, .PROC_WAIT_IN, .PROC_TS1_IN, .MEM_ACK_IN, .PROC_START_OUT,
   .PROC_RUN_ENABLE_OUT, .MEM_REQ_OUT, .MEM_WE_OUT, .MEM_ADDR_OUT, .STATUS_LAMPS_OUT);
`default_nettype wire
